// *** hdl/dmsp_serial_port.sv ***
`timescale 1ns/1ps
module dmsp_serial_port (
    input  wire logic                        clock,          // Device clock, 200 MHz.
    input  wire logic                        rst,            // Asynchronous reset, active high.
    input  wire logic                        interface_select_pin, // High I2C, low SPI.
    input  wire logic                        select_or_target_addr_pin, // SS or address select.
    input  wire logic                        link_clk_pin,   // SCLK or SCL.
    input  wire logic                        shared_serial_in_pin, // SDI or SDA input.
    output logic                             sda_out,        // SDA output level.
    output logic                             sda_oe,         // SDA drive enable, high pulls low.
    input  wire logic                        shared_serial_out_in, // PWM input level in I2C mode.
    output logic                             shared_serial_out_pin, // SDO data.
    output logic                             shared_serial_out_oe, // SDO drive enable.
    output logic                             dimming_in,     // Synchronised PWM dimming input.
    output logic                             i2c_mode,       // Latched mode, high for I2C.
    output logic                             reg_wr_en,      // Register write strobe.
    output logic                             reg_rd_en,      // Register read strobe.
    output logic [dmsp_pkg::ADDR_W-1:0]      reg_addr,       // Register address.
    output logic [dmsp_pkg::DATA_W-1:0]      reg_wdata,      // Register write data.
    input  wire logic [dmsp_pkg::DATA_W-1:0] reg_rdata       // Register read data, same cycle.
);
    localparam int DW = dmsp_pkg::DATA_W;
    localparam int AW = dmsp_pkg::ADDR_W;

    typedef enum logic [2:0] {DMSP_IDLE, DMSP_DEVADDR, DMSP_REGADDR, DMSP_WDATA, DMSP_RDATA, DMSP_IGNORE} dmsp_i2c_e;

    dmsp_reg_if rif ();
    logic [4:0] s;
    logic       sel_s, clk_s, din_s, pwm_s, interface_select_pin_s;
    logic       clk_d_ff, din_d_ff, mode_done_ff, mode_ff;

    dmsp_sync #(.W(5)) u_sync (
        .clock (clock),
        .rst   (rst),
        .d     ({interface_select_pin, select_or_target_addr_pin, link_clk_pin,
                 shared_serial_in_pin, shared_serial_out_in}),
        .q     (s)
    );
    assign {interface_select_pin_s, sel_s, clk_s, din_s, pwm_s} = s;

    logic rise, fall;
    assign rise = clk_s & ~clk_d_ff;
    assign fall = ~clk_s & clk_d_ff;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clk_d_ff <= 1'b1;
            din_d_ff <= 1'b1;
        end else begin
            clk_d_ff <= clk_s;
            din_d_ff <= din_s;
        end
    end

    // The mode strap is taken after the synchroniser has filled, never from the port under reset.
    logic [1:0] strap_cnt_ff;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            strap_cnt_ff <= 2'h0;
            mode_done_ff <= 1'b0;
            mode_ff      <= 1'b0;
        end else if (!mode_done_ff) begin
            strap_cnt_ff <= strap_cnt_ff + 2'h1;
            if (strap_cnt_ff == 2'h3) begin
                mode_done_ff <= 1'b1;
                mode_ff      <= interface_select_pin_s;
            end
        end
    end
    assign i2c_mode   = mode_ff;
    assign dimming_in = mode_ff & pwm_s;

    // SPI engine, active only in SPI mode after strap capture.
    logic                 spi_on;
    logic [5:0]           bit_cnt_ff;
    logic [DW-1:0]        sh_ff;
    logic [AW-1:0]        spi_addr_ff;
    logic                 spi_rw_ff, spi_wr_ff, spi_rd_ff, sdo_ff, sdo_oe_ff;
    logic [DW-1:0]        out_sh_ff;
    assign spi_on = mode_done_ff & ~mode_ff;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bit_cnt_ff  <= dmsp_pkg::SPI_CNT_RST;
            sh_ff       <= '0;
            spi_addr_ff <= '0;
            spi_rw_ff   <= 1'b0;
            spi_wr_ff   <= 1'b0;
            spi_rd_ff   <= 1'b0;
        end else begin
            spi_wr_ff <= 1'b0;
            spi_rd_ff <= 1'b0;
            if (!spi_on || sel_s) begin
                bit_cnt_ff <= dmsp_pkg::SPI_CNT_RST;
                spi_rw_ff  <= 1'b0;
            end else if (rise) begin
                sh_ff <= {sh_ff[DW-2:0], din_s};
                if (bit_cnt_ff == 6'(dmsp_pkg::SPI_ADDR_W - 1))
                    spi_addr_ff <= {sh_ff[AW-2:0], din_s};
                if (bit_cnt_ff == 6'(dmsp_pkg::SPI_RW_POS - 1)) begin
                    spi_rw_ff <= din_s;
                    spi_rd_ff <= ~din_s;
                end
                if (bit_cnt_ff == 6'(dmsp_pkg::SPI_FRAME_W - 1)) begin
                    spi_wr_ff  <= spi_rw_ff;
                    bit_cnt_ff <= 6'(dmsp_pkg::SPI_RW_POS);
                end else begin
                    bit_cnt_ff <= bit_cnt_ff + 6'h01;
                end
            end else if (spi_wr_ff) begin
                spi_addr_ff <= spi_addr_ff + 10'h001;
            end
        end
    end

    // Read data leaves on falling edges; the read word is loaded the cycle after R/W is taken.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            out_sh_ff <= '0;
            sdo_ff    <= 1'b0;
            sdo_oe_ff <= 1'b0;
        end else if (!spi_on || sel_s) begin
            sdo_ff    <= 1'b0;
            sdo_oe_ff <= 1'b0;
        end else begin
            sdo_oe_ff <= (bit_cnt_ff < 6'(dmsp_pkg::SPI_RW_POS)) || !spi_rw_ff;
            if (spi_rd_ff)
                out_sh_ff <= reg_rdata;
            else if (fall && !spi_rw_ff && bit_cnt_ff >= 6'(dmsp_pkg::SPI_RW_POS)) begin
                sdo_ff    <= out_sh_ff[DW-1];
                out_sh_ff <= {out_sh_ff[DW-2:0], 1'b0};
            end else if (bit_cnt_ff < 6'(dmsp_pkg::SPI_RW_POS))
                sdo_ff <= 1'b0;
        end
    end
    assign shared_serial_out_pin = sdo_ff;
    assign shared_serial_out_oe  = sdo_oe_ff;

    // I2C target engine.
    dmsp_i2c_e     st_ff;
    logic [3:0]    ibit_ff;
    logic [7:0]    ish_ff;
    logic [1:0]    win_ff;
    logic [7:0]    ilow_ff;
    logic          rd_dir_ff, ack_ff, ibyte_ff, i_wr_ff, i_rd_ff, sda_oe_ff, sda_o_ff;
    logic [DW-1:0] idata_ff;
    logic          i2c_on, start_c, stop_c;
    logic [6:0]    base;
    assign i2c_on  = mode_done_ff & mode_ff;
    assign start_c = i2c_on & clk_s & clk_d_ff & din_d_ff & ~din_s;
    assign stop_c  = i2c_on & clk_s & clk_d_ff & ~din_d_ff & din_s;
    assign base    = sel_s ? dmsp_pkg::I2C_BASE_HIGH : dmsp_pkg::I2C_BASE_LOW;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_ff     <= DMSP_IDLE;
            ibit_ff   <= dmsp_pkg::I2C_BIT_RST;
            ish_ff    <= '0;
            win_ff    <= '0;
            ilow_ff   <= '0;
            rd_dir_ff <= 1'b0;
            ack_ff    <= 1'b0;
            ibyte_ff  <= 1'b0;
            idata_ff  <= '0;
            i_wr_ff   <= 1'b0;
            i_rd_ff   <= 1'b0;
            sda_oe_ff <= 1'b0;
        end else begin
            i_wr_ff <= 1'b0;
            i_rd_ff <= 1'b0;
            if (!i2c_on || stop_c) begin
                st_ff     <= DMSP_IDLE;
                sda_oe_ff <= 1'b0;
            end else if (start_c) begin
                st_ff     <= DMSP_DEVADDR;
                ibit_ff   <= dmsp_pkg::I2C_BIT_RST;
                ack_ff    <= 1'b0;
                sda_oe_ff <= 1'b0;
            end else if (rise && st_ff != DMSP_IDLE && st_ff != DMSP_IGNORE) begin
                if (!ack_ff) begin
                    ish_ff  <= {ish_ff[6:0], din_s};
                    ibit_ff <= ibit_ff + 4'h1;
                end else if (st_ff == DMSP_RDATA && din_s) begin
                    st_ff <= DMSP_IGNORE;                // Master NACK ends the read.
                end
            end else if (fall && st_ff != DMSP_IDLE && st_ff != DMSP_IGNORE) begin
                if (ack_ff) begin
                    ack_ff    <= 1'b0;
                    sda_oe_ff <= 1'b0;
                    ibit_ff   <= dmsp_pkg::I2C_BIT_RST;
                    if (st_ff == DMSP_RDATA) begin
                        sda_oe_ff <= ~idata_ff[DW-1];
                        idata_ff  <= {idata_ff[DW-2:0], 1'b0};
                    end
                end else if (ibit_ff == 4'h8) begin
                    ack_ff    <= 1'b1;
                    sda_oe_ff <= 1'b1;
                    case (st_ff)
                        DMSP_DEVADDR: begin
                            if (ish_ff[7:3] == base[6:2]) begin
                                win_ff    <= ish_ff[2:1];
                                rd_dir_ff <= ish_ff[0];
                                ibyte_ff  <= 1'b0;
                                if (ish_ff[0]) begin
                                    st_ff    <= DMSP_RDATA;
                                    i_rd_ff  <= 1'b1;
                                end else begin
                                    st_ff <= DMSP_REGADDR;
                                end
                            end else begin
                                st_ff     <= DMSP_IGNORE;
                                ack_ff    <= 1'b0;
                                sda_oe_ff <= 1'b0;
                            end
                        end
                        DMSP_REGADDR: begin
                            ilow_ff <= ish_ff;
                            st_ff   <= DMSP_WDATA;
                        end
                        DMSP_WDATA: begin
                            idata_ff <= {idata_ff[7:0], ish_ff};
                            ibyte_ff <= ~ibyte_ff;
                            i_wr_ff  <= ibyte_ff;
                        end
                        DMSP_RDATA: begin
                            sda_oe_ff <= 1'b0;           // Master acknowledges the byte.
                        end
                        default: st_ff <= DMSP_IGNORE;
                    endcase
                end else if (st_ff == DMSP_RDATA) begin
                    sda_oe_ff <= ~idata_ff[DW-1];
                    idata_ff  <= {idata_ff[DW-2:0], 1'b0};
                end
            end else if (i_rd_ff) begin
                idata_ff <= reg_rdata;
            end
        end
    end
    // The first read bit is shifted out at the fall ending the address acknowledge.
    assign sda_out = 1'b0;
    assign sda_oe  = sda_oe_ff;

    // The port has no power gating, so standby access is unaffected.
    assign rif.wr_en = spi_wr_ff | i_wr_ff;
    assign rif.rd_en = spi_rd_ff | i_rd_ff;
    assign rif.addr  = mode_ff ? {win_ff, ilow_ff} : spi_addr_ff;
    assign rif.wdata = mode_ff ? idata_ff : sh_ff;
    assign rif.rdata = reg_rdata;
    assign reg_wr_en = rif.wr_en;
    assign reg_rd_en = rif.rd_en;
    assign reg_addr  = rif.addr;
    assign reg_wdata = rif.wdata;
endmodule : dmsp_serial_port

// *** hdl/dmsp_pkg.sv ***
package dmsp_pkg;
    localparam int          ADDR_W        = 10;
    localparam int          DATA_W        = 16;
    localparam int          SPI_FRAME_W   = 32;
    localparam int          SPI_ADDR_W    = 15;
    localparam int          SPI_RW_POS    = 16;
    localparam logic [6:0]  I2C_BASE_LOW  = 7'h2c;
    localparam logic [6:0]  I2C_BASE_HIGH = 7'h3c;
    localparam logic [5:0]  SPI_CNT_RST   = 6'h00;
    localparam logic [3:0]  I2C_BIT_RST   = 4'h0;
    localparam logic [1:0]  I2C_BYTE_RST  = 2'h0;
endpackage : dmsp_pkg

// *** hdl/dmsp_reg_if.sv ***
`timescale 1ns/1ps
interface dmsp_reg_if;
    logic                          wr_en;
    logic                          rd_en;
    logic [dmsp_pkg::ADDR_W-1:0]   addr;
    logic [dmsp_pkg::DATA_W-1:0]   wdata;
    logic [dmsp_pkg::DATA_W-1:0]   rdata;
    modport port (output wr_en, output rd_en, output addr, output wdata, input rdata);
    modport regs (input wr_en, input rd_en, input addr, input wdata, output rdata);
endinterface : dmsp_reg_if

// *** hdl/dmsp_sync.sv ***
`timescale 1ns/1ps
module dmsp_sync #(
    parameter int W = 4
) (
    input  wire logic         clock, // Device clock.
    input  wire logic         rst,   // Asynchronous reset, active high.
    input  wire logic [W-1:0] d,     // Asynchronous inputs.
    output logic      [W-1:0] q      // Synchronised outputs.
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_ff <= '0;
            q       <= '0;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule : dmsp_sync

// *** verification/dmsp_serial_port_props.sv ***
`timescale 1ns/1ps
module dmsp_serial_port_props (
    input wire logic clock,                     // Device clock.
    input wire logic rst,                       // Reset, active high.
    input wire logic select_or_target_addr_pin, // SS in SPI mode.
    input wire logic shared_serial_out_in,      // PWM level.
    input wire logic sda_out,                   // SDA output level.
    input wire logic sda_oe,                    // SDA enable.
    input wire logic shared_serial_out_oe,      // SDO enable.
    input wire logic dimming_in,                // Dimming copy.
    input wire logic i2c_mode,                  // Latched mode.
    input wire logic reg_wr_en,                 // Write strobe.
    input wire logic reg_rd_en                  // Read strobe.
);
    logic [3:0] up_ff;

    // The mode-hold and SPI-mode pin checks wait until the strap has surely been latched.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            up_ff <= 4'h0;
        end else if (up_ff != 4'hf) begin
            up_ff <= up_ff + 4'h1;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    sequence ss_idle_s;
        !i2c_mode && select_or_target_addr_pin [*8];
    endsequence
    sequence pwm_high_s;
        i2c_mode && shared_serial_out_in [*4];
    endsequence

    strobe_excl_a: assert property (!(reg_wr_en && reg_rd_en))
        else $error("write and read strobes together");
    wr_pulse_a: assert property (reg_wr_en |=> !reg_wr_en)
        else $error("write strobe longer than one cycle");
    sdo_idle_a: assert property (ss_idle_s |-> !shared_serial_out_oe)
        else $error("SDO driven while deselected");
    ss_quiet_a: assert property (ss_idle_s |-> !reg_wr_en && !reg_rd_en)
        else $error("register access while deselected");
    mode_hold_a: assert property (up_ff == 4'hf |-> $stable(i2c_mode))
        else $error("mode changed after startup");
    sda_spi_a: assert property (up_ff == 4'hf && !i2c_mode |-> !sda_oe && !dimming_in)
        else $error("I2C pins active in SPI mode");
    sdo_i2c_a: assert property (i2c_mode |-> !shared_serial_out_oe)
        else $error("SDO driven in I2C mode");
    dim_follow_a: assert property (pwm_high_s |-> dimming_in)
        else $error("dimming input not following pin");
    sda_low_a: assert property (sda_out == 1'b0)
        else $error("SDA driven high");
endmodule : dmsp_serial_port_props

bind dmsp_serial_port dmsp_serial_port_props u_dmsp_serial_port_props (
    .clock(clock), .rst(rst), .select_or_target_addr_pin(select_or_target_addr_pin),
    .shared_serial_out_in(shared_serial_out_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .shared_serial_out_oe(shared_serial_out_oe), .dimming_in(dimming_in), .i2c_mode(i2c_mode),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en));

// *** verification/dmsp_host_model.sv ***
`timescale 1ns/1ps
module dmsp_host_model (
    input  wire logic clock, // Pacing clock.
    input  wire logic din,   // SDO or SDA as seen on the wire.
    input  wire logic oe,    // SDO enable, counted per bit.
    output logic      sclk,  // SCLK or SCL.
    output logic      ss_n,  // Slave select, active low.
    output logic      dout   // SDI, or the host's open-drain SDA level.
);
    int oe_cnt;

    initial begin
        sclk = 1'b0;
        ss_n = 1'b1;
        dout = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(negedge clock);
    endtask : w
    // Data moves while the clock is low and is taken late in the high phase.
    task automatic bit_clk(input logic v, output logic r);
        sclk = 1'b0;
        w(4);
        dout = v;
        w(4);
        sclk = 1'b1;
        w(8);
        r = din;
        oe_cnt += int'(oe === 1'b1);
    endtask : bit_clk
    task automatic shift16(input logic [15:0] tx, output logic [15:0] rx);
        oe_cnt = 0;
        for (int i = 15; i >= 0; i--) bit_clk(tx[i], rx[i]);
        sclk = 1'b0;
    endtask : shift16
    // SS stays low over the frame and rises between frames.
    task automatic spi_frame(input logic [14:0] a, input logic rw, input logic [15:0] d,
                             input logic more, input logic [15:0] d2, output logic [15:0] rx);
        logic [15:0] dummy;
        ss_n = 1'b0;
        w(8);
        shift16({a, rw}, dummy);
        shift16(d, rx);
        if (more) shift16(d2, dummy);
        w(8);
        ss_n = 1'b1;
        w(16);
    endtask : spi_frame
    task automatic i2c_cond(input logic start);
        logic r;
        bit_clk(start, r);
        dout = ~start;
        w(8);
    endtask : i2c_cond
    task automatic i2c_byte(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) bit_clk(tx[i], rx[i]);
    endtask : i2c_byte
endmodule : dmsp_host_model

// *** verification/dual_mode_serial_register_port_bench.sv ***
`timescale 1ns/1ps
module dual_mode_serial_register_port_bench;
    typedef struct packed {logic [14:0] a; logic [9:0] ea; logic [15:0] d;} dmsp_row_s;
    logic                        clock, rst, strap, i2c_bus, addr_sel, pwm_lvl, nak;
    logic                        sda_out, sda_oe, sdo, sdo_oe, dimming_in, i2c_mode, sclk, ss_n, hd;
    logic                        reg_wr_en, reg_rd_en;
    logic [dmsp_pkg::ADDR_W-1:0] reg_addr;
    logic [dmsp_pkg::DATA_W-1:0] reg_wdata, reg_rdata_w, rx, mem [0:1023];
    logic [8:0]                  r9, hi, lo;
    int                          fails, n_compared, n_reads;
    wire                         sda_w = hd & (~sda_oe | sda_out);
    // Undecoded address bits are set in some rows to show they are ignored.
    dmsp_row_s rows [4] = '{'{15'h0020, 10'h020, 16'h0300}, '{15'h7c28, 10'h028, 16'ha55a},
                            '{15'h02ae, 10'h2ae, 16'hffff}, '{15'h4054, 10'h054, 16'h8001}};

    always #2.5 clock = ~clock;
    always @(posedge clock) if (reg_wr_en === 1'b1) mem[reg_addr] <= reg_wdata;
    always @(posedge clock) if (reg_rd_en === 1'b1) n_reads++;
    assign reg_rdata_w = mem[reg_addr];
    dmsp_serial_port u_dmsp_serial_port (.clock(clock), .rst(rst), .interface_select_pin(strap),
        .select_or_target_addr_pin(i2c_bus ? addr_sel : ss_n), .link_clk_pin(sclk),
        .shared_serial_in_pin(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .shared_serial_out_in(pwm_lvl),
        .shared_serial_out_pin(sdo), .shared_serial_out_oe(sdo_oe), .dimming_in(dimming_in),
        .i2c_mode(i2c_mode), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata_w));
    dmsp_host_model u_dmsp_host_model (.clock(clock), .din(i2c_bus ? sda_w : (sdo_oe ? sdo : ~sdo)),
        .oe(sdo_oe), .sclk(sclk), .ss_n(ss_n), .dout(hd));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    task automatic send(input logic [7:0] b);
        u_dmsp_host_model.i2c_byte({b, 1'b1}, r9);
        nak |= r9[0];
    endtask : send
    task automatic reset_to(input logic mode);
        rst = 1'b1;
        strap = mode;
        i2c_bus = mode;
        u_dmsp_host_model.sclk = mode;
        repeat (10) @(negedge clock);
        check("oe in reset", {15'h0, sdo_oe}, 16'h0000);
        rst = 1'b0;
        repeat (16) @(negedge clock);
        check("mode", {15'h0, i2c_mode}, {15'h0, mode});
    endtask : reset_to

    initial begin
        #200us;
        fails++;
        tally_and_finish();
    end
    initial begin
        clock = 1'b0;
        {fails, n_compared, n_reads, nak, addr_sel, pwm_lvl} = '0;
        foreach (mem[i]) mem[i] = 16'h0000;
        reset_to(1'b0);
        strap = 1'b1;
        foreach (rows[i]) begin
            u_dmsp_host_model.spi_frame(rows[i].a, 1'b1, rows[i].d, 1'b0, 16'h0000, rx);
            check("write", mem[rows[i].ea], rows[i].d);
            check("sdo in write", 16'(u_dmsp_host_model.oe_cnt), 16'h0000);
            u_dmsp_host_model.spi_frame(rows[i].a, 1'b0, 16'h0000, 1'b0, 16'h0000, rx);
            check("read", rx, rows[i].d);
            check("sdo in read", 16'(u_dmsp_host_model.oe_cnt), 16'h0010);
        end
        check("mode kept", {15'h0, i2c_mode}, 16'h0000);
        check("spi reads", 16'(n_reads), 16'h0004);
        $display("test spi rows done");
        u_dmsp_host_model.spi_frame(15'h0100, 1'b1, 16'h1234, 1'b1, 16'h5678, rx);
        check("auto first", mem[10'h100], 16'h1234);
        check("auto next", mem[10'h101], 16'h5678);
        $display("test auto increment done");
        u_dmsp_host_model.ss_n = 1'b0;
        u_dmsp_host_model.w(8);
        u_dmsp_host_model.shift16({15'h0050, 1'b1}, rx);
        u_dmsp_host_model.ss_n = 1'b1;
        u_dmsp_host_model.w(16);
        u_dmsp_host_model.spi_frame(15'h0052, 1'b1, 16'ha5a5, 1'b0, 16'h0000, rx);
        check("aborted", mem[10'h050], 16'h0000);
        check("after abort", mem[10'h052], 16'ha5a5);
        $display("test abort done");
        pwm_lvl = 1'b1;
        reset_to(1'b1);
        check("dimming", {15'h0, dimming_in}, 16'h0001);
        u_dmsp_host_model.i2c_cond(1'b1);
        u_dmsp_host_model.i2c_byte({8'h78, 1'b1}, r9);
        u_dmsp_host_model.i2c_cond(1'b0);
        check("foreign ack", {15'h0, r9[0]}, 16'h0001);
        u_dmsp_host_model.i2c_cond(1'b1);
        foreach (rows[i]) send(i == 0 ? 8'h5a : i == 1 ? 8'h3c : i == 2 ? 8'hbe : 8'hef);
        u_dmsp_host_model.i2c_cond(1'b0);
        check("i2c write", mem[10'h13c], 16'hbeef);
        u_dmsp_host_model.i2c_cond(1'b1);
        send(8'h5a);
        send(8'h3c);
        u_dmsp_host_model.i2c_cond(1'b1);
        send(8'h5b);
        u_dmsp_host_model.i2c_byte({8'hff, 1'b0}, hi);
        u_dmsp_host_model.i2c_byte({8'hff, 1'b1}, lo);
        u_dmsp_host_model.i2c_cond(1'b0);
        check("i2c read", {hi[8:1], lo[8:1]}, 16'hbeef);
        check("i2c reads", 16'(n_reads), 16'h0005);
        addr_sel = 1'b1;
        u_dmsp_host_model.i2c_cond(1'b1);
        send(8'h7c);
        send(8'h88);
        send(8'h12);
        send(8'h34);
        u_dmsp_host_model.i2c_cond(1'b0);
        check("high base write", mem[10'h288], 16'h1234);
        pwm_lvl = 1'b0;
        repeat (4) @(negedge clock);
        check("dimming low", {15'h0, dimming_in}, 16'h0000);
        check("i2c acks", {15'h0, nak}, 16'h0000);
        $display("test i2c done");
        tally_and_finish();
    end
endmodule : dual_mode_serial_register_port_bench
